// >>> logic/boot_loader_pkg.sv
// Constants and types shared by the dual slot boot and image update loader.
package boot_loader_pkg;
    // Flash geometry and flag layout.
    localparam logic [23:0] LOW_BASE = 24'h000000;
    localparam logic [23:0] FLAG_OFS = 24'h000020;
    localparam logic [7:0] FLAG_OK = 8'h4B;
    localparam logic [7:0] FLAG_OLD = 8'h00;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [23:0] SECTOR_MASK = 24'h000FFF;
    localparam int BLOCK_SHIFT = 4;
    // Legal upper slot addresses and their maximum image sizes.
    localparam logic [23:0] SLOT_128K = 24'h020000;
    localparam logic [23:0] SLOT_256K = 24'h040000;
    localparam logic [23:0] SLOT_512K = 24'h080000;
    localparam logic [23:0] SLOT_DEFAULT = SLOT_256K;
    localparam logic [23:0] MAX_124K = 24'h01F000;
    localparam logic [23:0] MAX_252K = 24'h03F000;
    localparam logic [23:0] MAX_508K = 24'h07F000;
    // Flash operation codes.
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;
    // Slot configuration answers.
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_INVALID_PARAM = 8'h01;
    // Data buffer shape.
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    // Update timeout.
    localparam longint CLK_HZ = 125000000;
    localparam longint TIMEOUT_MS = 30000;
    localparam longint TIMEOUT_CYCLES = TIMEOUT_MS * CLK_HZ / 1000;
    typedef enum {
        ST_BOOT0, ST_BOOT1, ST_HALT, ST_COPY, ST_SCAN, ST_ERASE, ST_IDLE,
        ST_UPD, ST_FLAG_NEW, ST_FLAG_OLD, ST_NOTIFY, ST_REBOOT
    } state_e;
endpackage : boot_loader_pkg

// >>> logic/boot_image_loader.sv
// Dual slot boot selector, image copier and over-the-air image update engine.
`timescale 1ns/1ns

module byte_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_flush,
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic ready_r;
    logic push;
    logic pop;

    // Handshakes on both sides; ready is held in a flop.
    assign push = i_valid && ready_r;
    assign pop = i_ready && (cnt_r != '0);
    assign o_ready = ready_r;
    assign o_valid = (cnt_r != '0);
    assign o_data = mem_r[rd_r];
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    // Storage is written only on an accepted push.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_r] <= i_data;
        end
    end

    // Pointers and fill level; a flush empties the buffer.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || i_flush) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
        end else begin
            wr_r <= wr_r + AW'(push);
            rd_r <= rd_r + AW'(pop);
            cnt_r <= cnt_nxt;
            ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule : byte_fifo

module boot_image_loader
    import boot_loader_pkg::*;
#(
    parameter logic [31:0] TIMEOUT_CYC = 32'(TIMEOUT_CYCLES),
    parameter int SIZE_SHIFT = 0
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [23:0] i_pc,
    output logic [23:0] o_fetch_addr,
    output logic o_boot_done,
    output logic o_boot_halt,
    output logic o_ram_we,
    output logic [23:0] o_ram_addr,
    output logic [7:0] o_ram_data,
    output logic o_fl_req,
    output logic [1:0] o_fl_op,
    output logic [23:0] o_fl_addr,
    output logic [7:0] o_fl_wdata,
    input wire logic i_fl_ack,
    input wire logic [7:0] i_fl_rdata,
    input wire logic i_start,
    input wire logic i_img_valid,
    input wire logic [7:0] i_img_data,
    output logic o_img_ready,
    input wire logic i_end,
    input wire logic i_end_has_idx,
    input wire logic [15:0] i_end_idx,
    input wire logic [15:0] i_end_idx_x,
    input wire logic i_pkt_err,
    input wire logic i_pkt_lost,
    output logic o_notify,
    output logic o_result_ok,
    output logic o_reboot,
    input wire logic i_cfg_valid,
    input wire logic [23:0] i_cfg_addr,
    output logic o_cfg_done,
    output logic [7:0] o_cfg_status
);
    state_e state_r;
    logic fl_req_r;
    logic [1:0] fl_op_r;
    logic [23:0] fl_addr_r;
    logic [7:0] fl_wdata_r;
    logic want;
    logic [1:0] want_op;
    logic [23:0] want_addr;
    logic [7:0] want_data;
    logic [23:0] cnt_r;
    logic [23:0] boot_base_r;
    logic [23:0] new_ofs_r;
    logic [23:0] slot_r;
    logic [23:0] max_len_r;
    logic [23:0] erase_len;
    logic ram_we_r;
    logic [23:0] ram_addr_r;
    logic [7:0] ram_data_r;
    logic notify_r;
    logic result_ok_r;
    logic reboot_r;
    logic [23:0] fetch_r;
    logic boot_done_r;
    logic halt_r;
    logic cfg_done_r;
    logic [7:0] cfg_status_r;
    logic end_pend_r;
    logic end_has_r;
    logic [15:0] end_idx_r;
    logic [15:0] end_x_r;
    logic end_ok;
    logic fail_r;
    logic [31:0] tmr_r;
    logic f_valid;
    logic [7:0] f_data;
    logic f_pop;
    logic cfg_legal;

    assign o_fl_req = fl_req_r;
    assign o_fl_op = fl_op_r;
    assign o_fl_addr = fl_addr_r;
    assign o_fl_wdata = fl_wdata_r;
    assign o_ram_we = ram_we_r;
    assign o_ram_addr = ram_addr_r;
    assign o_ram_data = ram_data_r;
    assign o_notify = notify_r;
    assign o_result_ok = result_ok_r;
    assign o_reboot = reboot_r;
    assign o_fetch_addr = fetch_r;
    assign o_boot_done = boot_done_r;
    assign o_boot_halt = halt_r;
    assign o_cfg_done = cfg_done_r;
    assign o_cfg_status = cfg_status_r;
    assign erase_len = slot_r >> SIZE_SHIFT;

    // Image data is buffered; anything sent outside update mode is dropped.
    byte_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_flush(state_r != ST_UPD),
        .i_valid(i_img_valid),
        .i_data(i_img_data),
        .o_ready(o_img_ready),
        .o_valid(f_valid),
        .o_data(f_data),
        .i_ready(f_pop)
    );

    // A byte leaves the buffer only while no flash write is pending.
    assign f_pop = (state_r == ST_UPD) && !fl_req_r && f_valid && !fail_r
        && (cnt_r < max_len_r);

    // The final block index must match its complement and the byte count.
    assign end_ok = !end_has_r || ((end_idx_r == ~end_x_r) && (cnt_r != '0)
        && (end_idx_r == 16'((cnt_r - 24'h000001) >> BLOCK_SHIFT)));

    // Flash request wanted by each state.
    always_comb begin
        want = 1'b0;
        want_op = OP_READ;
        want_addr = '0;
        want_data = '0;
        case (state_r)
            ST_BOOT0: begin
                want = 1'b1;
                want_addr = LOW_BASE + FLAG_OFS;
            end
            ST_BOOT1: begin
                want = 1'b1;
                want_addr = slot_r + FLAG_OFS;
            end
            ST_COPY: begin
                want = (cnt_r < (max_len_r));
                want_addr = boot_base_r + cnt_r;
            end
            ST_SCAN: begin
                want = (cnt_r < erase_len);
                want_addr = new_ofs_r + cnt_r;
            end
            ST_ERASE: begin
                want = 1'b1;
                want_op = OP_ERASE;
                want_addr = new_ofs_r + (cnt_r & ~SECTOR_MASK);
            end
            ST_UPD: begin
                want = f_pop;
                want_op = OP_WRITE;
                want_addr = new_ofs_r + cnt_r;
                want_data = f_data;
            end
            ST_FLAG_NEW: begin
                want = 1'b1;
                want_op = OP_WRITE;
                want_addr = new_ofs_r + FLAG_OFS;
                want_data = FLAG_OK;
            end
            ST_FLAG_OLD: begin
                want = 1'b1;
                want_op = OP_WRITE;
                want_addr = boot_base_r + FLAG_OFS;
                want_data = FLAG_OLD;
            end
            default: begin
                want = 1'b0;
            end
        endcase
    end

    // Flash bus: a request is held until the single-cycle acknowledge.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fl_req_r <= 1'b0;
            fl_op_r <= OP_READ;
            fl_addr_r <= '0;
            fl_wdata_r <= '0;
        end else if (!fl_req_r && want) begin
            fl_req_r <= 1'b1;
            fl_op_r <= want_op;
            fl_addr_r <= want_addr;
            fl_wdata_r <= want_data;
        end else if (i_fl_ack) begin
            fl_req_r <= 1'b0;
        end
    end

    // Main sequencer: boot selection, copy, erase, update and flag swap.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= ST_BOOT0;
            cnt_r <= '0;
            boot_base_r <= LOW_BASE;
            new_ofs_r <= '0;
            ram_we_r <= 1'b0;
            ram_addr_r <= '0;
            ram_data_r <= '0;
            notify_r <= 1'b0;
            result_ok_r <= 1'b0;
            reboot_r <= 1'b0;
            end_pend_r <= 1'b0;
            end_has_r <= 1'b0;
            end_idx_r <= '0;
            end_x_r <= '0;
        end else begin
            ram_we_r <= 1'b0;
            notify_r <= 1'b0;
            reboot_r <= 1'b0;
            if (state_r == ST_UPD && i_end && !end_pend_r) begin
                end_pend_r <= 1'b1;
                end_has_r <= i_end_has_idx;
                end_idx_r <= i_end_idx;
                end_x_r <= i_end_idx_x;
            end
            case (state_r)
                ST_BOOT0: begin
                    if (fl_req_r && i_fl_ack) begin
                        cnt_r <= '0;
                        if (i_fl_rdata == FLAG_OK) begin
                            boot_base_r <= LOW_BASE;
                            state_r <= ST_COPY;
                        end else begin
                            state_r <= ST_BOOT1;
                        end
                    end
                end
                ST_BOOT1: begin
                    if (fl_req_r && i_fl_ack) begin
                        if (i_fl_rdata == FLAG_OK) begin
                            boot_base_r <= slot_r;
                            state_r <= ST_COPY;
                        end else begin
                            state_r <= ST_HALT;
                        end
                    end
                end
                ST_COPY: begin
                    if (fl_req_r && i_fl_ack) begin
                        ram_we_r <= 1'b1;
                        ram_addr_r <= cnt_r;
                        ram_data_r <= i_fl_rdata;
                        cnt_r <= cnt_r + 24'h000001;
                    end else if (!fl_req_r && !want) begin
                        new_ofs_r <= (boot_base_r == LOW_BASE) ? slot_r : LOW_BASE;
                        cnt_r <= '0;
                        state_r <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (fl_req_r && i_fl_ack) begin
                        if (i_fl_rdata != ERASED) begin
                            state_r <= ST_ERASE;
                        end else begin
                            cnt_r <= cnt_r + 24'h000001;
                        end
                    end else if (!fl_req_r && !want) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_ERASE: begin
                    if (fl_req_r && i_fl_ack) begin
                        cnt_r <= (cnt_r | SECTOR_MASK) + 24'h000001;
                        state_r <= ST_SCAN;
                    end
                end
                ST_IDLE: begin
                    if (i_start) begin
                        cnt_r <= '0;
                        end_pend_r <= 1'b0;
                        state_r <= ST_UPD;
                    end
                end
                ST_UPD: begin
                    if (fl_req_r && i_fl_ack) begin
                        cnt_r <= cnt_r + 24'h000001;
                    end else if (!fl_req_r && fail_r) begin
                        result_ok_r <= 1'b0;
                        state_r <= ST_NOTIFY;
                    end else if (!fl_req_r && end_pend_r && !f_valid) begin
                        result_ok_r <= 1'b0;
                        state_r <= end_ok ? ST_FLAG_NEW : ST_NOTIFY;
                    end
                end
                ST_FLAG_NEW: begin
                    if (fl_req_r && i_fl_ack) begin
                        state_r <= ST_FLAG_OLD;
                    end
                end
                ST_FLAG_OLD: begin
                    if (fl_req_r && i_fl_ack) begin
                        result_ok_r <= 1'b1;
                        state_r <= ST_NOTIFY;
                    end
                end
                ST_NOTIFY: begin
                    notify_r <= 1'b1;
                    state_r <= ST_REBOOT;
                end
                ST_REBOOT: begin
                    reboot_r <= 1'b1;
                    state_r <= ST_BOOT0;
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // Update timer and failure latch, both cleared outside update mode.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || state_r != ST_UPD) begin
            tmr_r <= '0;
            fail_r <= 1'b0;
        end else begin
            tmr_r <= tmr_r + 32'h00000001;
            if (i_pkt_err || i_pkt_lost || tmr_r == TIMEOUT_CYC - 32'h00000001
                || (f_valid && !fl_req_r && cnt_r >= max_len_r)) begin
                fail_r <= 1'b1;
            end
        end
    end

    // Upper slot configuration and the image size limit it implies.
    assign cfg_legal = (i_cfg_addr == SLOT_128K) || (i_cfg_addr == SLOT_256K)
        || (i_cfg_addr == SLOT_512K);
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            slot_r <= SLOT_DEFAULT;
            max_len_r <= MAX_252K >> SIZE_SHIFT;
            cfg_done_r <= 1'b0;
            cfg_status_r <= STATUS_OK;
        end else begin
            cfg_done_r <= i_cfg_valid;
            if (i_cfg_valid) begin
                if (cfg_legal) begin
                    slot_r <= i_cfg_addr;
                    cfg_status_r <= STATUS_OK;
                end else begin
                    cfg_status_r <= STATUS_INVALID_PARAM;
                end
            end
            if (slot_r == SLOT_128K) begin
                max_len_r <= MAX_124K >> SIZE_SHIFT;
            end else if (slot_r == SLOT_512K) begin
                max_len_r <= MAX_508K >> SIZE_SHIFT;
            end else begin
                max_len_r <= MAX_252K >> SIZE_SHIFT;
            end
        end
    end

    // Fetch address is the chosen base plus the program counter.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fetch_r <= '0;
            boot_done_r <= 1'b0;
            halt_r <= 1'b0;
        end else begin
            fetch_r <= boot_base_r + i_pc;
            boot_done_r <= !(state_r inside {ST_BOOT0, ST_BOOT1, ST_HALT, ST_COPY, ST_REBOOT});
            halt_r <= (state_r == ST_HALT);
        end
    end

    a_first_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_BOOT0 && fl_req_r) |-> (fl_addr_r == FLAG_OFS && fl_op_r == OP_READ))
        else $error("first boot read not at low flag");
    a_low_pick: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_BOOT0 && fl_req_r && i_fl_ack && i_fl_rdata == FLAG_OK)
        |=> (state_r == ST_COPY && boot_base_r == LOW_BASE) ##1 (fetch_r == $past(i_pc)))
        else $error("low image not selected");
    a_high_pick: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_BOOT1 && fl_req_r && i_fl_ack && i_fl_rdata == FLAG_OK)
        |=> (state_r == ST_COPY && boot_base_r == $past(slot_r)))
        else $error("upper image not selected");
    a_no_marker: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_BOOT1 && fl_req_r && i_fl_ack && i_fl_rdata != FLAG_OK)
        |=> state_r == ST_HALT ##1 halt_r)
        else $error("missing marker did not halt");
    a_new_offset: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_COPY ##1 state_r == ST_SCAN)
        |-> new_ofs_r == ((boot_base_r == LOW_BASE) ? $past(slot_r) : LOW_BASE))
        else $error("new image offset wrong");
    a_dirty_erase: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_SCAN && fl_req_r && i_fl_ack && i_fl_rdata != ERASED)
        |=> !fl_req_r ##1 (fl_req_r && fl_op_r == OP_ERASE))
        else $error("dirty byte not erased");
    a_write_region: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_UPD && fl_req_r) |-> (fl_op_r == OP_WRITE && fl_addr_r >= new_ofs_r
        && fl_addr_r < new_ofs_r + max_len_r))
        else $error("image write outside new region");
    a_flag_swap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_FLAG_NEW && fl_req_r) |-> (fl_addr_r == new_ofs_r + FLAG_OFS
        && fl_wdata_r == FLAG_OK))
        else $error("new flag write wrong");
    a_notify_reboot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        notify_r |=> reboot_r ##1 (state_r == ST_BOOT0))
        else $error("reboot did not follow result");
    a_fail_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_UPD && (i_pkt_err || i_pkt_lost)) |=> (fail_r || state_r != ST_UPD))
        else $error("packet fault not latched");
    a_cfg_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        i_cfg_valid |=> cfg_done_r && ((cfg_status_r == STATUS_OK) == $past(cfg_legal)))
        else $error("slot configuration answer wrong");
    a_start_enter: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (state_r == ST_IDLE && i_start) |=> (state_r == ST_UPD && cnt_r == '0))
        else $error("start did not enter update");
endmodule : boot_image_loader

// >>> dv/flash_model.sv
// Behavioural serial flash holding two images, with random answer delay.
`timescale 1ns/1ns

module flash_model (
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic [1:0] i_op,
    input wire logic [23:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_ack,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [logic [23:0]];
    int cnt = 0;
    int lat = 1;

    // Unwritten bytes read back as the erased value.
    function automatic logic [7:0] rd(input logic [23:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction : rd

    initial o_ack = 1'b0;
    initial o_rdata = 8'h5A;

    // Answers each request once after a random wait; data toggles when idle.
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            if (cnt >= lat) begin
                cnt <= 0;
                lat <= $urandom_range(3, 0);
                o_ack <= 1'b1;
                if (i_op == 2'h0) o_rdata <= rd(i_addr);
                // Programming can only clear bits.
                if (i_op == 2'h1) mem[i_addr] = rd(i_addr) & i_wdata;
                if (i_op == 2'h2) begin
                    for (int i = 0; i < 4096; i++) begin
                        mem[{i_addr[23:12], 12'h000} + 24'(i)] = 8'hFF;
                    end
                end
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : flash_model

// >>> dv/test_dual_slot_boot_image_update.sv
// Self-checking bench for the dual slot boot and image update loader.
`timescale 1ns/1ns

module test_dual_slot_boot_image_update;
    import boot_loader_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

    logic i_clk = 0, i_sys_rst = 1, i_fl_ack, i_start = 0, i_img_valid = 0, i_end = 0;
    logic i_end_has_idx = 0, i_pkt_err = 0, i_pkt_lost = 0, i_cfg_valid = 0;
    logic [23:0] i_pc = 0, i_cfg_addr = 0, o_fetch_addr, o_ram_addr, o_fl_addr, base = 0;
    logic [7:0] i_img_data = 0, i_fl_rdata, o_ram_data, o_fl_wdata, o_cfg_status;
    logic [15:0] i_end_idx = 0, i_end_idx_x = 0;
    logic [1:0] o_fl_op;
    logic o_boot_done, o_boot_halt, o_ram_we, o_fl_req, o_img_ready, o_notify;
    logic o_result_ok, o_reboot, o_cfg_done, saw_full = 0;
    int fails = 0, samples_checked = 0, cyc = 0, n_ram = 0;
    logic [7:0] sent [$];

    always #4 i_clk = ~i_clk;

    boot_image_loader #(.TIMEOUT_CYC(32'd200), .SIZE_SHIFT(12)) u_dut (.i_clk, .i_sys_rst,
        .i_pc, .o_fetch_addr, .o_boot_done, .o_boot_halt, .o_ram_we, .o_ram_addr, .o_ram_data,
        .o_fl_req, .o_fl_op, .o_fl_addr, .o_fl_wdata, .i_fl_ack, .i_fl_rdata, .i_start,
        .i_img_valid, .i_img_data, .o_img_ready, .i_end, .i_end_has_idx, .i_end_idx,
        .i_end_idx_x, .i_pkt_err, .i_pkt_lost, .o_notify, .o_result_ok, .o_reboot,
        .i_cfg_valid, .i_cfg_addr, .o_cfg_done, .o_cfg_status);

    flash_model u_fl (.i_clk, .i_req(o_fl_req), .i_op(o_fl_op), .i_addr(o_fl_addr),
        .i_wdata(o_fl_wdata), .o_ack(i_fl_ack), .o_rdata(i_fl_rdata));

    // Every copied byte must match the flash image of the chosen slot.
    always @(negedge i_clk) begin
        if (o_ram_we === 1'b1) begin
            n_ram++;
            `CHK(o_ram_data, u_fl.rd(base + o_ram_addr))
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    // Cuts a hang short.
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            wrap_up();
        end
    end

    // Waits for boot, copy and spare-slot clean-up to finish, then checks the fetch base.
    task automatic settle;
        int q;
        int t;
        q = 0;
        t = 0;
        repeat (3) @(negedge i_clk);
        while ((o_boot_done !== 1'b1 || q < 10) && t < 5000) begin
            @(negedge i_clk);
            t++;
            q = (o_fl_req === 1'b0) ? q + 1 : 0;
        end
        `CHK(o_fetch_addr, base + i_pc)
        `CHK(n_ram, 63)
        n_ram = 0;
    endtask : settle

    // One update: mode 0 good, 1 packet error, 2 lost packet, 3 timeout, 4 bad index.
    task automatic run_update(input int n, input int mode);
        logic r;
        int t;
        sent.delete();
        @(posedge i_clk) i_start <= 1'b1;
        @(posedge i_clk) i_start <= 1'b0;
        for (int k = 0; k < n; k++) begin
            sent.push_back(8'($urandom));
            i_img_valid <= 1'b1;
            i_img_data <= sent[k];
            do begin
                @(negedge i_clk) r = o_img_ready;
                if (!r) saw_full = 1'b1;
                @(posedge i_clk);
            end while (!r);
        end
        i_img_valid <= 1'b0;
        i_pkt_err <= (mode == 1);
        i_pkt_lost <= (mode == 2);
        i_end <= (mode == 0 || mode == 4);
        i_end_has_idx <= (mode == 4) || 1'($urandom);
        i_end_idx <= 16'((n - 1) >> 4);
        i_end_idx_x <= ~16'((n - 1) >> 4) ^ 16'(mode == 4);
        @(posedge i_clk) {i_end, i_pkt_err, i_pkt_lost} <= 3'h0;
        t = 0;
        do begin
            @(negedge i_clk);
            t++;
        end while (o_notify !== 1'b1 && t < 3000);
        `CHK(o_result_ok, 1'(mode == 0))
        @(negedge i_clk);
        `CHK(o_reboot, 1'b1)
    endtask : run_update

    initial begin
        logic [7:0] st;
        void'($urandom(92341));
        for (int k = 0; k < 64; k++) u_fl.mem[24'(k)] = 8'($urandom);
        u_fl.mem[24'h000020] = FLAG_OK;
        u_fl.mem[24'h040005] = 8'h12;
        i_pc <= 24'($urandom);
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        settle();
        `CHK(u_fl.rd(24'h040005), ERASED)
        // Slot configuration: the three legal addresses and one illegal one.
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk) i_cfg_valid <= 1'b1;
            i_cfg_addr <= (k == 0) ? SLOT_128K : (k == 1) ? SLOT_512K
                : (k == 2) ? 24'h030000 : SLOT_DEFAULT;
            st = (k == 2) ? STATUS_INVALID_PARAM : STATUS_OK;
            @(posedge i_clk) i_cfg_valid <= 1'b0;
            @(negedge i_clk);
            `CHK(o_cfg_done, 1'b1)
            `CHK(o_cfg_status, st)
        end
        run_update(28 + $urandom_range(4, 0), 0);
        foreach (sent[k]) `CHK(u_fl.rd(SLOT_DEFAULT + 24'(k)), sent[k])
        `CHK(u_fl.rd(SLOT_DEFAULT + FLAG_OFS), FLAG_OK)
        `CHK(u_fl.rd(FLAG_OFS), FLAG_OLD)
        `CHK(saw_full, 1'b1)
        base = SLOT_DEFAULT;
        settle();
        `CHK(u_fl.rd(FLAG_OFS), ERASED)
        for (int m = 1; m < 5; m++) begin
            run_update((m == 3) ? 0 : 20, m);
            settle();
            `CHK(u_fl.rd(SLOT_DEFAULT + FLAG_OFS), FLAG_OK)
        end
        // Neither flag valid: the loader must stop without booting.
        u_fl.mem[SLOT_DEFAULT + FLAG_OFS] = 8'h4A;
        @(posedge i_clk) i_sys_rst <= 1'b1;
        @(posedge i_clk) i_sys_rst <= 1'b0;
        repeat (100) @(negedge i_clk);
        `CHK(o_boot_halt, 1'b1)
        `CHK(o_boot_done, 1'b0)
        wrap_up();
    end
endmodule : test_dual_slot_boot_image_update
